//--- tac_cfg.svh
// Constants of the temperature alarm core: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the alarm engine and core modules.
`ifndef TAC_CFG_SVH
`define TAC_CFG_SVH

// APB byte addresses
`define TAC_ADDR_TEMP 8'h00
`define TAC_ADDR_CONFIG 8'h04
`define TAC_ADDR_LOWER 8'h08
`define TAC_ADDR_UPPER 8'h0C
`define TAC_ADDR_POINTER 8'h10
`define TAC_ADDR_WINDOW 8'h14
`define TAC_ADDR_STATUS 8'h18

// Pointer codes
`define TAC_PTR_TEMP 2'h0
`define TAC_PTR_CONFIG 2'h1
`define TAC_PTR_LOWER 2'h2
`define TAC_PTR_UPPER 2'h3
`define TAC_PTR_RESET 2'h0
`define TAC_PTR_MSB 1
`define TAC_PTR_ZERO_HI 7
`define TAC_PTR_ZERO_LO 2

// Configuration fields
`define TAC_CFG_SHUTDOWN 0
`define TAC_CFG_MODE 1
`define TAC_CFG_POLARITY 2
`define TAC_CFG_FAULT_LO 3
`define TAC_CFG_FAULT_HI 4
`define TAC_CFG_RES_LO 5
`define TAC_CFG_RES_HI 6
`define TAC_CFG_MSB 6
`define TAC_CONFIG_RESET 7'h00

// Threshold resets and hardwired-zero low nibble
`define TAC_UPPER_RESET 16'h5000
`define TAC_LOWER_RESET 16'h4B00
`define TAC_TEMP_RESET 16'h0000
`define TAC_THR_MASK 16'hFFF0
`define TAC_LOW_PAD 4'h0

// Resolution masks, 9 to 12 bits
`define TAC_RES9_MASK 16'hFF80
`define TAC_RES10_MASK 16'hFFC0
`define TAC_RES11_MASK 16'hFFE0
`define TAC_RES12_MASK 16'hFFF0

// Fault counts per select code
`define TAC_FAULT_SEL0 3'h1
`define TAC_FAULT_SEL1 3'h2
`define TAC_FAULT_SEL2 3'h4
`define TAC_FAULT_SEL3 3'h6

// Status fields
`define TAC_ST_ACTIVE 0
`define TAC_ST_AWAIT_LOW 1
`define TAC_ST_COUNT_LO 2
`define TAC_ST_COUNT_HI 4
`define TAC_ST_SHUTDOWN 5

// Timing
`define TAC_CONV_TIME_US 90000
`define TAC_CLK_MHZ 20
`define TAC_TIMER_W 21

`endif

//--- tac_pkg.sv
// Types shared by the temperature alarm core.
// Assumes tac_cfg.svh on the include path.
package tac_pkg;

  typedef enum logic [1:0] {
    TAC_WAIT_HIGH = 2'b00,
    TAC_ACTIVE_HIGH = 2'b01,
    TAC_WAIT_LOW = 2'b10,
    TAC_ACTIVE_LOW = 2'b11
  } tac_alarm_state_t;

  typedef enum logic [1:0] {
    TAC_SEL_TEMP = 2'b00,
    TAC_SEL_CONFIG = 2'b01,
    TAC_SEL_LOWER = 2'b10,
    TAC_SEL_UPPER = 2'b11
  } tac_reg_sel_t;

endpackage

//--- tac_alarm_engine.sv
// Alarm engine: consecutive fault counting and comparator/interrupt states.
// Assumes eval pulses once per conversion with compare results alongside.
`timescale 1ns/1ps
`include "tac_cfg.svh"

module tac_alarm_engine (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic eval,
  input wire logic above_upper,
  input wire logic below_lower,
  input wire logic [1:0] fault_sel,
  input wire logic interrupt_mode,
  input wire logic host_read,
  input wire logic shutdown_enter,
  output logic alarm_active,
  output logic await_low,
  output logic [2:0] fault_count
);

  tac_pkg::tac_alarm_state_t state;
  tac_pkg::tac_alarm_state_t next_state;
  tac_pkg::tac_alarm_state_t cleared;
  logic [2:0] next_count;
  logic mode_q;

  function automatic logic [2:0] tac_fault_need(input logic [1:0] sel);
    unique case (sel)
      2'b00: tac_fault_need = `TAC_FAULT_SEL0;
      2'b01: tac_fault_need = `TAC_FAULT_SEL1;
      2'b10: tac_fault_need = `TAC_FAULT_SEL2;
      2'b11: tac_fault_need = `TAC_FAULT_SEL3;
    endcase
  endfunction

  always_comb begin
    cleared = state;
    // Host read or shutdown only clears in interrupt mode
    if (interrupt_mode && (host_read || shutdown_enter)) begin
      if (state == tac_pkg::TAC_ACTIVE_HIGH) begin
        cleared = tac_pkg::TAC_WAIT_LOW;
      end else if (state == tac_pkg::TAC_ACTIVE_LOW) begin
        cleared = tac_pkg::TAC_WAIT_HIGH;
      end
    end
    next_state = cleared;
    next_count = (cleared != state) ? 3'h0 : fault_count;
    // A conversion landing with a clear counts toward the new wait
    if (interrupt_mode != mode_q) begin
      next_state = tac_pkg::TAC_WAIT_HIGH;
      next_count = 3'h0;
    end else if (eval) begin
      unique case (cleared)
        tac_pkg::TAC_WAIT_HIGH: begin
          if (above_upper) begin
            if (next_count + 3'h1 >= tac_fault_need(fault_sel)) begin
              next_state = tac_pkg::TAC_ACTIVE_HIGH;
              next_count = 3'h0;
            end else begin
              next_count = next_count + 3'h1;
            end
          end else begin
            next_count = 3'h0;
          end
        end
        tac_pkg::TAC_ACTIVE_HIGH: begin
          if (!interrupt_mode && below_lower) begin
            next_state = tac_pkg::TAC_WAIT_HIGH;
            next_count = 3'h0;
          end
        end
        tac_pkg::TAC_WAIT_LOW: begin
          if (below_lower) begin
            if (next_count + 3'h1 >= tac_fault_need(fault_sel)) begin
              next_state = tac_pkg::TAC_ACTIVE_LOW;
              next_count = 3'h0;
            end else begin
              next_count = next_count + 3'h1;
            end
          end else begin
            next_count = 3'h0;
          end
        end
        tac_pkg::TAC_ACTIVE_LOW: begin
          next_state = cleared;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= tac_pkg::TAC_WAIT_HIGH;
      fault_count <= 3'h0;
    end else begin
      state <= next_state;
      fault_count <= next_count;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 1'b0;
    end else begin
      mode_q <= interrupt_mode;
    end
  end

  assign alarm_active = state[0];
  assign await_low = state[1];

endmodule

//--- tac_core.sv
// Temperature alarm core: APB registers, conversion timebase, result
// formatting, threshold compare and the open-drain over-limit pin.
// Assumes sensor_code comes from same-clock front-end logic, always valid.
`timescale 1ns/1ps
`include "tac_cfg.svh"

module tac_core #(
  parameter int CONV_CYCLES = `TAC_CONV_TIME_US * `TAC_CLK_MHZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [11:0] sensor_code,
  output logic conversion_done,
  output logic alarm_active,
  output logic os_out,
  output logic os_oe
);

  logic [15:0] temp_result;
  logic [15:0] upper_thr;
  logic [15:0] lower_thr;
  logic [`TAC_CFG_MSB:0] config_q;
  logic [`TAC_PTR_MSB:0] pointer;
  logic [`TAC_TIMER_W-1:0] timer;
  logic conv_tick;
  logic [15:0] conv_word;
  logic temp_read_busy;
  logic setup_phase;
  logic access_done;
  logic wr_done;
  logic rd_done;
  logic sel_valid;
  tac_pkg::tac_reg_sel_t sel_reg;
  logic pointer_bad;
  logic [15:0] compare_mask;
  logic above_upper;
  logic below_lower;
  logic shutdown_enter;
  logic engine_active;
  logic engine_await_low;
  logic [2:0] engine_count;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic next_oe;

  logic shutdown;
  logic interrupt_mode;
  logic polarity;
  logic [1:0] fault_sel;
  logic [1:0] res_sel;

  assign shutdown = config_q[`TAC_CFG_SHUTDOWN];
  assign interrupt_mode = config_q[`TAC_CFG_MODE];
  assign polarity = config_q[`TAC_CFG_POLARITY];
  assign fault_sel = config_q[`TAC_CFG_FAULT_HI:`TAC_CFG_FAULT_LO];
  assign res_sel = config_q[`TAC_CFG_RES_HI:`TAC_CFG_RES_LO];

  // Mask of bits that carry temperature at a given resolution
  function automatic logic [15:0] tac_res_mask(input logic [1:0] res);
    unique case (res)
      2'b00: tac_res_mask = `TAC_RES9_MASK;
      2'b01: tac_res_mask = `TAC_RES10_MASK;
      2'b10: tac_res_mask = `TAC_RES11_MASK;
      2'b11: tac_res_mask = `TAC_RES12_MASK;
    endcase
  endfunction

  // Maps a bus address, through the pointer for the window, to a register
  function automatic tac_pkg::tac_reg_sel_t tac_decode(
    input logic [7:0] addr,
    input logic [`TAC_PTR_MSB:0] ptr
  );
    unique case (addr)
      `TAC_ADDR_TEMP: tac_decode = tac_pkg::TAC_SEL_TEMP;
      `TAC_ADDR_CONFIG: tac_decode = tac_pkg::TAC_SEL_CONFIG;
      `TAC_ADDR_LOWER: tac_decode = tac_pkg::TAC_SEL_LOWER;
      `TAC_ADDR_UPPER: tac_decode = tac_pkg::TAC_SEL_UPPER;
      default: tac_decode = tac_pkg::tac_reg_sel_t'(ptr);
    endcase
  endfunction

  function automatic logic tac_is_reg(input logic [7:0] addr);
    tac_is_reg = (addr == `TAC_ADDR_TEMP) || (addr == `TAC_ADDR_CONFIG) ||
                 (addr == `TAC_ADDR_LOWER) || (addr == `TAC_ADDR_UPPER) ||
                 (addr == `TAC_ADDR_WINDOW);
  endfunction

  // Bus phase decode; the slave never inserts wait states
  assign pready = 1'b1;
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready;
  assign wr_done = access_done && pwrite;
  assign rd_done = access_done && !pwrite;
  assign sel_reg = tac_decode(paddr, pointer);
  assign sel_valid = tac_is_reg(paddr);
  // Nonzero upper pointer bits terminate the operation
  assign pointer_bad =
    |pwdata[`TAC_PTR_ZERO_HI:`TAC_PTR_ZERO_LO];

  // Conversion timebase, held idle during shutdown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer <= '0;
    end else if (shutdown) begin
      timer <= '0;
    end else if (timer == `TAC_TIMER_W'(CONV_CYCLES - 1)) begin
      timer <= '0;
    end else begin
      timer <= timer + `TAC_TIMER_W'(1);
    end
  end

  assign conv_tick = !shutdown &&
                     (timer == `TAC_TIMER_W'(CONV_CYCLES - 1));

  // Left-aligned, sign first, truncated to the chosen resolution
  assign conv_word = {sensor_code, `TAC_LOW_PAD} &
                     tac_res_mask(res_sel);

  // A result read in flight keeps its old value; the compare still runs
  assign temp_read_busy = psel && !pwrite &&
                          sel_valid && (sel_reg == tac_pkg::TAC_SEL_TEMP);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_result <= `TAC_TEMP_RESET;
    end else if (conv_tick && !temp_read_busy) begin
      temp_result <= conv_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_done <= 1'b0;
    end else begin
      conversion_done <= conv_tick;
    end
  end

  // Configuration register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_q <= `TAC_CONFIG_RESET;
    end else if (wr_done && sel_valid &&
                 sel_reg == tac_pkg::TAC_SEL_CONFIG) begin
      config_q <= pwdata[`TAC_CFG_MSB:0];
    end
  end

  assign shutdown_enter = wr_done && sel_valid &&
                          (sel_reg == tac_pkg::TAC_SEL_CONFIG) &&
                          pwdata[`TAC_CFG_SHUTDOWN] && !shutdown;

  // Thresholds; low nibble is hardwired zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_thr <= `TAC_UPPER_RESET;
    end else if (wr_done && sel_valid &&
                 sel_reg == tac_pkg::TAC_SEL_UPPER) begin
      upper_thr <= pwdata[15:0] & `TAC_THR_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lower_thr <= `TAC_LOWER_RESET;
    end else if (wr_done && sel_valid &&
                 sel_reg == tac_pkg::TAC_SEL_LOWER) begin
      lower_thr <= pwdata[15:0] & `TAC_THR_MASK;
    end
  end

  // Register pointer for the window address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pointer <= `TAC_PTR_RESET;
    end else if (wr_done && paddr == `TAC_ADDR_POINTER && !pointer_bad) begin
      pointer <= pwdata[`TAC_PTR_MSB:0];
    end
  end

  // Compare at the active resolution; lower threshold bits are don't care
  assign compare_mask = tac_res_mask(res_sel);
  assign above_upper = $signed(conv_word) >
                       $signed(upper_thr & compare_mask);
  assign below_lower = $signed(conv_word) <
                       $signed(lower_thr & compare_mask);

  tac_alarm_engine u_engine (
    .pclk(pclk),
    .presetn(presetn),
    .eval(conv_tick),
    .above_upper(above_upper),
    .below_lower(below_lower),
    .fault_sel(fault_sel),
    .interrupt_mode(interrupt_mode),
    .host_read(rd_done && sel_valid),
    .shutdown_enter(shutdown_enter),
    .alarm_active(engine_active),
    .await_low(engine_await_low),
    .fault_count(engine_count)
  );

  assign alarm_active = engine_active;

  // Read data is captured in the setup cycle and held through access
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (paddr == `TAC_ADDR_POINTER) begin
      next_pslverr = pwrite && pointer_bad;
    end else if (paddr == `TAC_ADDR_STATUS) begin
      next_prdata[`TAC_ST_ACTIVE] = engine_active;
      next_prdata[`TAC_ST_AWAIT_LOW] = engine_await_low;
      next_prdata[`TAC_ST_COUNT_HI:`TAC_ST_COUNT_LO] = engine_count;
      next_prdata[`TAC_ST_SHUTDOWN] = shutdown;
    end else if (sel_valid) begin
      unique case (sel_reg)
        tac_pkg::TAC_SEL_TEMP: next_prdata[15:0] = temp_result;
        tac_pkg::TAC_SEL_CONFIG: next_prdata[`TAC_CFG_MSB:0] = config_q;
        tac_pkg::TAC_SEL_LOWER: next_prdata[15:0] = lower_thr;
        tac_pkg::TAC_SEL_UPPER: next_prdata[15:0] = upper_thr;
      endcase
    end else begin
      next_pslverr = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      pslverr <= next_pslverr;
    end else if (access_done) begin
      pslverr <= 1'b0;
    end
  end

  // Open drain: pull low when the pin level must be low
  assign next_oe = polarity ? !engine_active : engine_active;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      os_oe <= 1'b0;
    end else begin
      os_oe <= next_oe;
    end
  end

  assign os_out = 1'b0;

endmodule

//--- tac_core_monitor.sv
// Checker for the temperature alarm core, bound to its top ports.
// Assumes one pclk domain and a short CONV_CYCLES in simulation.
`timescale 1ns/1ps
module tac_core_monitor #(
  parameter int CONV_CYCLES = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic conversion_done,
  input wire logic alarm_active,
  input wire logic os_out,
  input wire logic os_oe
);
  logic [7:0] gap;
  logic armed;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Saturating gap count; shutdown only ever lengthens the gap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap <= 8'h00;
      armed <= 1'b0;
    end else if (conversion_done) begin
      gap <= 8'h00;
      armed <= 1'b1;
    end else if (gap != 8'hFF) begin
      gap <= gap + 8'h01;
    end
  end
  property p_ready_high; pready; endproperty
  a_ready_high: assert property (p_ready_high) else $error("pready low");
  property p_done_pulse; conversion_done |=> !conversion_done; endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done longer than one cycle");
  property p_done_gap; conversion_done && armed |-> gap >= CONV_CYCLES - 1;
  endproperty
  a_done_gap: assert property (p_done_gap)
    else $error("conversions too close");
  // The state moves at the tick edge, the same edge that raises the done
  // pulse; a read or shutdown clears one edge earlier, a mode write two.
  property p_alarm_cause;
    $changed(alarm_active) |-> conversion_done || $past(psel && penable)
      || $past(psel && penable && pwrite, 2);
  endproperty
  a_alarm_cause: assert property (p_alarm_cause)
    else $error("alarm moved without conversion");
  property p_pin_cause;
    $changed(os_oe) |-> $past(alarm_active, 2) != $past(alarm_active)
      || $past(psel && penable && pwrite, 2);
  endproperty
  a_pin_cause: assert property (p_pin_cause)
    else $error("pin moved without cause");
  property p_err_access; pslverr |-> psel && penable; endproperty
  a_err_access: assert property (p_err_access)
    else $error("error outside access");
  property p_err_unmapped; psel && !penable && paddr >= 8'h1C |=> pslverr;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped)
    else $error("no error on unmapped address");
  property p_zero_read;
    psel && !penable && !pwrite && paddr >= 8'h1C |=> prdata == 32'h0;
  endproperty
  a_zero_read: assert property (p_zero_read) else $error("unmapped read");
  property p_temp_pad;
    psel && penable && !pwrite && paddr == 8'h00 |-> prdata[3:0] == 4'h0;
  endproperty
  a_temp_pad: assert property (p_temp_pad)
    else $error("result pad bits set");
endmodule
bind tac_core tac_core_monitor #(.CONV_CYCLES(CONV_CYCLES)) tac_core_monitor_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .conversion_done(conversion_done),
  .alarm_active(alarm_active), .os_out(os_out), .os_oe(os_oe));

//--- tac_far_end.sv
// Far-end model: sensor front end and the pulled-up alarm wire.
// Assumes the bench sets the wanted sample on temp_set.
`timescale 1ns/1ps
module tac_far_end (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] temp_set,
  input wire logic os_out,
  input wire logic os_oe,
  output logic [11:0] sensor_code,
  output wire logic os_pin
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sensor_code <= 12'h000;
    end else begin
      sensor_code <= temp_set;
    end
  end
  // Pull-up wins whenever the drain is released
  assign os_pin = os_oe ? os_out : 1'b1;
endmodule

//--- tb_top.sv
// Self-checking bench for the temperature alarm core over APB.
// Assumes the far-end model supplies the sample and the pin pull-up.
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    n_tests++; \
    if ((g) !== (e)) begin \
      n_mismatch++; \
      $display("[ERR] %s exp %0h got %0h", nm, e, g); \
    end \
  end
module tb_top;
  localparam int CONV = 16;
  localparam logic [11:0] HOT = 12'h510;
  localparam logic [11:0] MID = 12'h4D0;
  localparam logic [11:0] COLD = 12'h400;
  typedef struct {
    logic [6:0] cfg;
    logic [11:0] code;
    logic [15:0] temp;
  } tac_row_t;
  tac_row_t rows [4] = '{'{7'h00, 12'hC8F, 16'hC880},
    '{7'h20, 12'h6A5, 16'h6A40}, '{7'h40, 12'hB37, 16'hB360},
    '{7'h60, 12'hF5B, 16'hF5B0}};
  logic [2:0] need [4] = '{3'h1, 3'h2, 3'h4, 3'h6};
  logic pclk = 1'b0, presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [11:0] temp_set = 12'h000;
  logic [31:0] prdata, rd;
  logic [11:0] sensor_code;
  logic pready, pslverr, err, conversion_done, alarm_active, os_out, os_oe;
  wire logic os_pin;
  int n_mismatch = 0, n_tests = 0, cyc = 0, n;

  always #25 pclk = ~pclk;

  tac_core #(.CONV_CYCLES(CONV)) tac_core_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sensor_code(sensor_code),
    .conversion_done(conversion_done), .alarm_active(alarm_active),
    .os_out(os_out), .os_oe(os_oe));
  tac_far_end tac_far_end_i (.pclk(pclk), .presetn(presetn),
    .temp_set(temp_set), .os_out(os_out), .os_oe(os_oe),
    .sensor_code(sensor_code), .os_pin(os_pin));

  // Entered just after an edge; leaves one idle cycle behind it
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("reg read", e, rd)
  endtask

  task automatic wait_conv();
    int w;
    w = 0;
    do begin
      @(posedge pclk);
      w++;
    end while (conversion_done !== 1'b1 && w < 64);
    if (conversion_done !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] conversion wait exp 1 got 0");
    end
  endtask

  // Two conversions when the sample may land just after a tick
  task automatic settle(input logic [11:0] c, input int k);
    temp_set <= c;
    repeat (k) wait_conv();
  endtask

  task automatic close_out();
    $display("Mismatches %0d in %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      apb(1'b1, 8'h04, {25'h0, rows[i].cfg});
      settle(rows[i].code, 2);
      rd_chk(8'h00, {16'h0, rows[i].temp});
    end
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(8'h04, 32'h0);
    rd_chk(8'h08, 32'h4B00);
    rd_chk(8'h0C, 32'h5000);
    rd_chk(8'h14, 32'h0);
    `CHK("pin idle", 1'b1, os_pin)
    apb(1'b0, 8'h1C, 32'h0);
    `CHK("slave error", 1'b1, err)
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, 8'h04, {27'h0, s[1:0], 3'b000});
      settle(COLD, 2);
      temp_set <= HOT;
      n = 0;
      do begin
        wait_conv();
        n++;
      end while (alarm_active !== 1'b1 && n < 8);
      `CHK("faults", need[s], n[2:0])
      // The pin flop follows the alarm state one edge later
      @(posedge pclk);
      `CHK("pin active", 1'b0, os_pin)
    end
    settle(MID, 2);
    `CHK("alarm hold", 1'b1, alarm_active)
    settle(COLD, 1);
    `CHK("alarm off", 1'b0, alarm_active)
    apb(1'b1, 8'h04, 32'h08);
    settle(HOT, 1);
    settle(MID, 1);
    settle(HOT, 1);
    `CHK("restart", 1'b0, alarm_active)
    settle(HOT, 1);
    `CHK("restart", 1'b1, alarm_active)
    apb(1'b1, 8'h04, 32'h04);
    settle(HOT, 1);
    @(posedge pclk);
    `CHK("pin high", 1'b1, os_pin)
    settle(COLD, 1);
    @(posedge pclk);
    `CHK("pin low", 1'b0, os_pin)
    apb(1'b1, 8'h04, 32'h02);
    settle(HOT, 1);
    `CHK("int set", 1'b1, alarm_active)
    rd_chk(8'h04, 32'h02);
    `CHK("int clear", 1'b0, alarm_active)
    settle(HOT, 1);
    `CHK("int wait", 1'b0, alarm_active)
    settle(COLD, 1);
    `CHK("int low", 1'b1, alarm_active)
    apb(1'b1, 8'h04, 32'h03);
    `CHK("sd clear", 1'b0, alarm_active)
    n = 0;
    repeat (3 * CONV) begin
      @(posedge pclk);
      if (conversion_done === 1'b1) n++;
    end
    `CHK("sd idle", 0, n)
    apb(1'b1, 8'h04, 32'h00);
    wait_conv();
    `CHK("resume", 1'b1, conversion_done)
    close_out();
  end
endmodule
